// [design/ip_source_selector.v]
// ip address source selector: switch decode, fallback timer, last byte
`include "ip_source_defines.vh"
`default_nettype none
// What this block does
// - position C asks the server for an address by mac, ignoring the tens switch.
// - in fallback mode, no server address within 120 s switches to the stored address.
// - the stored address defaults to 192.168.100.10 until changed.
// - a switch-built last byte keeps the stored first three bytes.
// - the switch last byte is ten times the tens switch plus the mode switch.
// - tens 0..F and mode 0..9 are taken; only results 1..159 are valid.
// - position E at power-up enters address clear mode and enables last byte entry.
// - address clear mode without a valid address gives a repeating two-flash pattern.
// - a valid last byte taken in address clear mode turns the indicator steady on.
// - a switch change after steady on returns to two flashes until a new valid value.
// - position D uses the stored address directly.
// - positions A and B ask the server by mac with no timed fallback.
// - position F takes the last byte from the mac, keeping stored first bytes.
// - mac last byte 00 maps to 1 and FF maps to 254.
module ip_source_selector #(
	parameter [63:0] FALLBACK_CYCLES = `FALLBACK_CYCLES,
	parameter FLASH_CYCLES = `FLASH_CYCLES,
	parameter [31:0] DEFAULT_IP = `DEFAULT_IP
)
(
	// clock and reset
	input wire ref_clk,
	input wire rst,
	// rotary switches
	input wire [3:0] mode_selector_switch,
	input wire [3:0] tens_selector_switch,
	// identity and stored address
	input wire [7:0] mac_last_byte,
	input wire nv_write,
	input wire [31:0] nv_write_data,
	// server side status
	input wire server_addr_valid,
	input wire [31:0] server_addr,
	// results
	output reg [2:0] source_mode,
	output reg request_server,
	output reg [31:0] ip_address,
	output reg ip_valid,
	output reg [31:0] nv_address,
	output reg status_led
);
	// ------------------------------------------------------------
	// power-up sampling of the mode switch
	// ------------------------------------------------------------
	reg sampled;
	reg fell_back;
	reg [63:0] fb_count;
	reg [7:0] last_byte;
	reg last_ok;
	reg [7:0] held_switches;
	reg [4:0] settle;
	wire led_flash;
	wire settled;
	wire flash_run;

	// sample once on the first edge after reset release, then hold
	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			sampled <= 1'b0;
			source_mode <= `SRC_SERVER;
		end
		else if (!sampled)
		begin
			sampled <= 1'b1;
			case (mode_selector_switch)
				`POS_DHCP_A, `POS_DHCP_B: source_mode <= `SRC_SERVER;
				`POS_FALLBACK: source_mode <= `SRC_FALLBACK;
				`POS_STORED: source_mode <= `SRC_STORED;
				`POS_CLEAR: source_mode <= `SRC_CLEAR;
				`POS_MAC: source_mode <= `SRC_MAC;
				default: source_mode <= `SRC_NAME;
			endcase
		end
	end

	// ------------------------------------------------------------
	// stored address
	// ------------------------------------------------------------
	// factory value after reset; software writes replace it
	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			nv_address <= `DEFAULT_IP;
		else if (nv_write)
			nv_address <= nv_write_data;
		else if (source_mode == `SRC_CLEAR && sampled && last_ok && settled)
			nv_address <= {nv_address[31:8], last_byte};
	end

	// ------------------------------------------------------------
	// last byte from the switches
	// ------------------------------------------------------------
	// combinational decode; tens range is fully covered by four bits
	always @*
	begin
		last_byte = {tens_selector_switch, 3'h0} + {tens_selector_switch, 1'b0}
			+ {4'h0, mode_selector_switch};
		last_ok = (mode_selector_switch <= 4'h9) && (last_byte >= `LAST_MIN)
			&& (last_byte <= `LAST_MAX);
	end

	// switches are hand turned, so a value must hold for a while before use
	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			held_switches <= 8'h00;
			settle <= 5'h00;
		end
		else if ({tens_selector_switch, mode_selector_switch} != held_switches)
		begin
			held_switches <= {tens_selector_switch, mode_selector_switch};
			settle <= 5'h00;
		end
		else if (settle != `SETTLE_CYCLES)
			settle <= settle + 5'h01;
	end

	// a value counts only once it has held still; the compare against the held
	// copy keeps the first edge of a new setting from slipping through unsettled
	assign settled = (settle == `SETTLE_CYCLES)
		&& ({tens_selector_switch, mode_selector_switch} == held_switches);

	// ------------------------------------------------------------
	// fallback timer
	// ------------------------------------------------------------
	// only fallback mode times out; other server modes wait forever
	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			fb_count <= 64'h0000000000000000;
			fell_back <= 1'b0;
		end
		else if (source_mode == `SRC_FALLBACK && sampled && !server_addr_valid && !fell_back)
		begin
			if (fb_count == FALLBACK_CYCLES - 64'h1)
				fell_back <= 1'b1;
			else
				fb_count <= fb_count + 64'h1;
		end
	end

	// ------------------------------------------------------------
	// address result and indicator
	// ------------------------------------------------------------
	// flashing only while clear mode still waits for a usable last byte
	assign flash_run = (source_mode == `SRC_CLEAR) && sampled && !ip_valid;

	flash_pattern #(
		.TICK(FLASH_CYCLES)
	)
	u_flash (
		.ref_clk(ref_clk),
		.rst(rst),
		.run(flash_run),
		.led(led_flash)
	);

	// one registered decision per mode
	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			request_server <= 1'b0;
			ip_address <= 32'h00000000;
			ip_valid <= 1'b0;
			status_led <= 1'b0;
		end
		else if (sampled)
		begin
			request_server <= 1'b0;
			ip_valid <= 1'b0;
			status_led <= 1'b0;
			case (source_mode)
				`SRC_SERVER, `SRC_NAME:
				begin
					request_server <= !server_addr_valid;
					ip_address <= server_addr;
					ip_valid <= server_addr_valid;
				end
				`SRC_FALLBACK:
				begin
					request_server <= !server_addr_valid && !fell_back;
					ip_address <= fell_back ? nv_address : server_addr;
					ip_valid <= server_addr_valid || fell_back;
				end
				`SRC_STORED:
				begin
					ip_address <= nv_address;
					ip_valid <= 1'b1;
				end
				`SRC_CLEAR:
				begin
					ip_address <= {nv_address[31:8], last_byte};
					ip_valid <= last_ok && settled;
					status_led <= (last_ok && settled) ? 1'b1
						: led_flash;
				end
				`SRC_MAC:
				begin
					if (mac_last_byte == 8'h00)
						ip_address <= {nv_address[31:8], `MAC_LOW_FIX};
					else if (mac_last_byte == 8'hFF)
						ip_address <= {nv_address[31:8], `MAC_HIGH_FIX};
					else
						ip_address <= {nv_address[31:8], mac_last_byte};
					ip_valid <= 1'b1;
				end
				default:
					ip_valid <= 1'b0;
			endcase
		end
	end
endmodule // ip_source_selector
`default_nettype wire

// [design/ip_source_defines.vh]
// constants for the ip address source selector
`ifndef IP_SOURCE_DEFINES_VH
`define IP_SOURCE_DEFINES_VH
// mode selector positions
`define POS_DHCP_A 4'hA
`define POS_DHCP_B 4'hB
`define POS_FALLBACK 4'hC
`define POS_STORED 4'hD
`define POS_CLEAR 4'hE
`define POS_MAC 4'hF
// source modes
`define SRC_SERVER 3'h0
`define SRC_FALLBACK 3'h1
`define SRC_STORED 3'h2
`define SRC_CLEAR 3'h3
`define SRC_MAC 3'h4
`define SRC_NAME 3'h5
// factory stored address
`define DEFAULT_IP 32'hC0A8640A
// last byte limits
`define LAST_MIN 8'h01
`define LAST_MAX 8'h9F
`define MAC_LOW_FIX 8'h01
`define MAC_HIGH_FIX 8'hFE
// timing
`define CLK_HZ 20000000
`define FALLBACK_S 120
// the product passes 2^31, so it is worked out in 64 bits to avoid wrapping
`define FALLBACK_CYCLES (64'h0000000000000001 * `FALLBACK_S * `CLK_HZ)
`define FLASH_MS 200
`define FLASH_CYCLES (`FLASH_MS * (`CLK_HZ / 1000))
`define SETTLE_CYCLES 16
`endif

// [design/flash_pattern.v]
// status indicator flash pattern generator: two flashes then a pause
`default_nettype none
module flash_pattern #(
	parameter TICK = 4000000
)
(
	// clock and reset
	input wire ref_clk,
	input wire rst,
	// control
	input wire run,
	// indicator level
	output reg led
);
	// ------------------------------------------------------------
	// tick divider and phase counter
	// ------------------------------------------------------------
	reg [31:0] tick_count;
	reg [2:0] phase;
	wire tick;
	assign tick = (tick_count == TICK - 1);

	// eight phases: on,off,on,off then four off for the pause
	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			tick_count <= 32'h00000000;
			phase <= 3'h0;
			led <= 1'b0;
		end
		else if (!run)
		begin
			tick_count <= 32'h00000000;
			phase <= 3'h0;
			led <= 1'b0;
		end
		else
		begin
			tick_count <= tick ? 32'h00000000 : tick_count + 32'h00000001;
			if (tick)
				phase <= phase + 3'h1;
			led <= (phase == 3'h0) || (phase == 3'h2);
		end
	end
endmodule // flash_pattern
`default_nettype wire

// [sim/ip_source_selector_props.sv]
// port assertions for the ip source selector
`default_nettype none
module ip_source_checker #(
	parameter [63:0] FALLBACK_CYCLES = 64'h000000008F0D1800
)
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// switches and identity
	input wire logic [3:0] mode_selector_switch,
	input wire logic [3:0] tens_selector_switch,
	input wire logic [7:0] mac_last_byte,
	// results
	input wire logic [2:0] source_mode,
	input wire logic request_server,
	input wire logic [31:0] ip_address,
	input wire logic ip_valid,
	input wire logic [31:0] nv_address,
	input wire logic status_led
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	logic [63:0] wait_cnt;
	// fallback wait length; a counter since the wait outgrows any repetition
	always_ff @(posedge ref_clk or posedge rst)
		if (rst || !request_server || source_mode != 3'h1) wait_cnt <= 64'h0;
		else wait_cnt <= wait_cnt + 64'h1;
	sequence asking_s;
		(source_mode == 3'h1 && !ip_valid) [*2];
	endsequence
	fb_req_a: assert property (asking_s |-> request_server)
		else $error("no server request");
	fb_bound_a: assert property (wait_cnt <= FALLBACK_CYCLES + 64'h2)
		else $error("fallback late");
	mac_byte_a: assert property (source_mode == 3'h4 |=> ip_address ==
		{$past(nv_address[31:8]), $past(mac_last_byte) == 8'h00 ? 8'h01 :
		$past(mac_last_byte) == 8'hFF ? 8'hFE : $past(mac_last_byte)}) else $error("mac byte");
	stored_ip_a: assert property (source_mode == 3'h2 |=> ip_valid &&
		ip_address == $past(nv_address)) else $error("stored address");
	clr_led_a: assert property (source_mode == 3'h3 && ip_valid |-> status_led)
		else $error("led not steady");
	clr_range_a: assert property (source_mode == 3'h3 && ip_valid |->
		ip_address[7:0] inside {[8'h01:8'h9F]}) else $error("byte out of range");
	clr_byte_a: assert property ($rose(ip_valid) && source_mode == 3'h3 |->
		ip_address == {nv_address[31:8], 8'(10 * $past(tens_selector_switch)
		+ $past(mode_selector_switch))}) else $error("switch byte");
	mode_hold_a: assert property (source_mode != 3'h0 |=> $stable(source_mode))
		else $error("mode moved");
endmodule // ip_source_checker
bind ip_source_selector ip_source_checker #(.FALLBACK_CYCLES(FALLBACK_CYCLES)) chk_u (
	.ref_clk(ref_clk), .rst(rst), .mode_selector_switch(mode_selector_switch),
	.tens_selector_switch(tens_selector_switch), .mac_last_byte(mac_last_byte),
	.source_mode(source_mode), .request_server(request_server), .ip_address(ip_address),
	.ip_valid(ip_valid), .nv_address(nv_address), .status_led(status_led));
`default_nettype wire

// [sim/addr_server_model.sv]
// behavioural address server facing the selector
`default_nettype none
module addr_server_model #(
	parameter [23:0] NET = 24'h0A0000
)
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// link to the selector
	input wire logic request_server,
	input wire logic answer_en,
	input wire logic [7:0] mac_last_byte,
	output logic server_addr_valid,
	output logic [31:0] server_addr
);
	timeunit 1ns;
	timeprecision 1ns;
	// answer late; the toggling word keeps a stale address from passing
	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			server_addr_valid <= 1'b0;
			server_addr <= 32'hA5A5A5A5;
		end
		else if (!server_addr_valid)
		begin
			server_addr_valid <= request_server && answer_en;
			server_addr <= (request_server && answer_en) ? {NET, mac_last_byte} : ~server_addr;
		end
	end
endmodule // addr_server_model
`default_nettype wire

// [sim/ip_source_selector_tb.sv]
// self-checking bench for the ip source selector
`default_nettype none
module ip_source_selector_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk, rst, nv_write, srv_valid, request_server, ip_valid, status_led, answer_en;
	logic [3:0] ms, ts;
	logic [7:0] mac;
	logic [31:0] nv_data, srv_addr, ip_address, nv_address;
	logic [2:0] source_mode;
	int miscompares, cmp_count;
	// short fallback and flash counts keep the run brief
	ip_source_selector #(.FALLBACK_CYCLES(64'h0000000000000064), .FLASH_CYCLES(4)) dut_u (
		.ref_clk(ref_clk),
		.rst(rst), .mode_selector_switch(ms), .tens_selector_switch(ts), .mac_last_byte(mac),
		.nv_write(nv_write), .nv_write_data(nv_data), .server_addr_valid(srv_valid),
		.server_addr(srv_addr), .source_mode(source_mode), .request_server(request_server),
		.ip_address(ip_address), .ip_valid(ip_valid), .nv_address(nv_address),
		.status_led(status_led));
	addr_server_model srv_u (.ref_clk(ref_clk), .rst(rst), .request_server(request_server),
		.answer_en(answer_en), .mac_last_byte(mac), .server_addr_valid(srv_valid),
		.server_addr(srv_addr));
	initial
	begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic conclude();
		$display("%0d compares, %0d wrong", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// power cycle with the mode switch set; results settle by the third edge
	task automatic boot(input logic [3:0] m);
		@(posedge ref_clk);
		rst <= 1'b1;
		ms <= m;
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (4) @(negedge ref_clk);
	endtask
	task automatic wait_valid(input int n);
		for (int i = 0; i < n && ip_valid !== 1'b1; i++)
			@(negedge ref_clk);
		chk(ip_valid, 1'b1);
		if (ip_valid !== 1'b1)
			conclude();
	endtask
	task automatic t_stored();
		boot(4'hD);
		chk(nv_address, 32'hC0A8640A);
		chk(ip_address, 32'hC0A8640A);
		@(posedge ref_clk);
		nv_write <= 1'b1;
		nv_data <= 32'h0A000105;
		@(posedge ref_clk);
		nv_write <= 1'b0;
		repeat (3) @(negedge ref_clk);
		chk(ip_address, 32'h0A000105);
		$display("test stored done");
	endtask
	task automatic t_mac();
		logic [7:0] m [3] = '{8'h00, 8'hFF, 8'hA7};
		logic [7:0] e [3] = '{8'h01, 8'hFE, 8'hA7};
		boot(4'hF);
		foreach (m[i])
		begin
			@(posedge ref_clk);
			mac <= m[i];
			repeat (2) @(negedge ref_clk);
			chk(ip_address, {24'hC0A864, e[i]});
		end
		$display("test mac done");
	endtask
	// silent server: the stored address must arrive, but not early
	task automatic t_fallback();
		int n;
		@(posedge ref_clk);
		ts <= 4'h7;
		boot(4'hC);
		chk(request_server, 1'b1);
		for (n = 0; n < 200 && ip_valid !== 1'b1; n++)
			@(negedge ref_clk);
		chk(ip_address, 32'hC0A8640A);
		chk(n >= 90 && n < 200, 1'b1);
		chk(request_server, 1'b0);
		if (ip_valid !== 1'b1)
			conclude();
		$display("test fallback done");
	endtask
	task automatic t_server();
		// position 5 lands in name mode, which asks the server the same way
		logic [3:0] p [3] = '{4'hA, 4'hB, 4'h5};
		mac <= 8'h33;
		foreach (p[i])
		begin
			answer_en <= 1'b0;
			boot(p[i]);
			repeat (150) @(negedge ref_clk);
			chk(ip_valid, 1'b0);
			chk(request_server, 1'b1);
			@(posedge ref_clk);
			answer_en <= 1'b1;
			wait_valid(20);
			chk(ip_address, 32'h0A000033);
		end
		$display("test server done");
	endtask
	task automatic t_clear();
		int k, rises;
		logic prev;
		@(posedge ref_clk);
		ts <= 4'h0;
		boot(4'hE);
		k = 0;
		rises = 0;
		@(posedge ref_clk);
		ms <= 4'h0;
		@(negedge ref_clk);
		prev = status_led;
		// one whole pattern period: eight phases of four cycles, two of them lit
		repeat (32)
		begin
			@(negedge ref_clk);
			k += status_led;
			rises += status_led & ~prev;
			prev = status_led;
		end
		chk(ip_valid, 1'b0);
		chk(k, 8);
		chk(rises, 2);
		@(posedge ref_clk);
		ts <= 4'h1;
		ms <= 4'h5;
		wait_valid(40);
		chk(ip_address, 32'hC0A8640F);
		chk(status_led, 1'b1);
		@(posedge ref_clk);
		ts <= 4'hF;
		ms <= 4'h9;
		repeat (3) @(negedge ref_clk);
		chk(ip_valid, 1'b0);
		wait_valid(40);
		chk(ip_address, 32'hC0A8649F);
		chk(source_mode, 3'h3);
		// a mode digit above nine is refused, though ten times zero plus A would fit
		@(posedge ref_clk);
		ts <= 4'h0;
		ms <= 4'hA;
		repeat (25) @(negedge ref_clk);
		chk(ip_valid, 1'b0);
		$display("test clear done");
	endtask
	initial
	begin
		rst = 1'b1;
		nv_write = 1'b0;
		nv_data = 32'h0;
		ms = 4'hD;
		ts = 4'h0;
		mac = 8'h0;
		answer_en = 1'b0;
		t_stored();
		t_mac();
		t_fallback();
		t_server();
		t_clear();
		conclude();
	end
endmodule // ip_source_selector_tb
`default_nettype wire
